// *** uifc_pkg.sv ***
// Constants shared by the interrupt, status and FIFO control block of one channel.
//
// Behaviour
// R01 - Receive trigger reached raises receive interrupt until below
// R02 - Data-ready sets on FIFO push, clears when empty
// R03 - Line status bit layout for polling
// R04 - Enable bit 0 gates receive-ready interrupt
// R05 - Enable bit 1 gates transmit-ready, fires if empty
// R06 - Enable bit 2 gates line-status; error timing selectable
// R07 - Enable bit 3 gates modem-status interrupt
// R08 - Enable bits 7:4 writable only with extended enable
// R09 - RTS rising edge under auto RTS interrupts
// R10 - CTS rising edge under auto CTS interrupts
// R11 - Status read returns highest pending priority code
// R12 - Time-out after four characters plus twelve bits
// R13 - Transmit ready uses fully empty in half-duplex; the logic does so only with the FIFO enabled, else it uses thr_empty_i
// R14 - Wake-up shows no-interrupt code, cleared by status read; the logic only forces status bit 0 high over any pending code
// R15 - Clearing of line, receive, time-out, transmit, modem
// R16 - Clearing of Xoff, special and flow-control interrupts
// R17 - Six-bit status codes by priority
// R18 - Status bit 0 low while anything pending
// R19 - Status bits 5:4 need extended enable
// R20 - Status bits 7:6 mirror FIFO enable
// R21 - FIFO enable must accompany other FIFO control bits
// R22 - Receive FIFO reset pulse, self-clearing
// R23 - Transmit FIFO reset pulse, self-clearing
// R24 - Interrupt output high while enabled source pending
// R25 - Read clears act after read data latched
package uifc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [7:0] OFF_INT_ENABLE = 8'h00;
   localparam logic [7:0] OFF_INT_STATUS = 8'h04;
   localparam logic [7:0] OFF_FIFO_CONTROL = 8'h08;
   localparam logic [7:0] OFF_LINE_STATUS = 8'h0C;
   localparam logic [7:0] OFF_MODEM_STATUS = 8'h10;
   localparam logic [7:0] OFF_RX_HOLDING = 8'h14;
   localparam logic [7:0] OFF_TX_HOLDING = 8'h18;
   localparam logic [7:0] OFF_EXT_FEATURE = 8'h1C;
   localparam logic [7:0] OFF_EXT_MODE = 8'h20;

   localparam logic [7:0] IER_RST = 8'h00;
   localparam logic [7:0] EFR_RST = 8'h00;
   localparam logic [7:0] EXTENDED_MODE_STATUS_RST = 8'h00;

   localparam int IER_RX = 0;
   localparam int IER_TX = 1;
   localparam int IER_LS = 2;
   localparam int IER_MS = 3;
   localparam int IER_SLEEP = 4;
   localparam int IER_XOFF = 5;
   localparam int IER_RTS = 6;
   localparam int IER_CTS = 7;
   localparam int EFR_EXT = 4;
   localparam int EXTENDED_MODE_STATUS_IMM_ERR = 6;

   localparam int FCR_EN = 0;
   localparam int FCR_RX_RST = 1;
   localparam int FCR_TX_RST = 2;
   localparam int FCR_DMA = 3;
   localparam int FCR_TX_TRIG = 4;
   localparam int FCR_RX_TRIG = 6;

   localparam logic [5:0] CODE_LS = 6'h06;
   localparam logic [5:0] CODE_TO = 6'h0C;
   localparam logic [5:0] CODE_RX = 6'h04;
   localparam logic [5:0] CODE_TX = 6'h02;
   localparam logic [5:0] CODE_MS = 6'h00;
   localparam logic [5:0] CODE_XS = 6'h10;
   localparam logic [5:0] CODE_RC = 6'h20;
   localparam logic [5:0] CODE_NONE = 6'h01;

   localparam int TO_CHARS = 4;
   localparam int TO_EXTRA_BITS = 12;
   localparam int TO_CNT_W = 8;
endpackage : uifc_pkg

// *** uifc_rx_timer.sv ***
// Receive time-out timer counting bit times while the receive FIFO holds data.
`timescale 1ns/10ps
`default_nettype none
module uifc_rx_timer #(
   parameter int CNT_W = uifc_pkg::TO_CNT_W
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic bit_tick_i,
   input wire logic [3:0] char_bits_i,
   input wire logic rx_empty_i,
   input wire logic restart_i,
   output logic expire_o
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] limit;
   logic armed;

   // Four whole characters plus twelve bit times.
   assign limit = CNT_W'(uifc_pkg::TO_CHARS * int'(char_bits_i) + uifc_pkg::TO_EXTRA_BITS); // R12

   // The timer fires once per idle spell; any FIFO activity re-arms it.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         count <= '0;
         armed <= 1'b1;
         expire_o <= 1'b0;
      end else begin
         expire_o <= 1'b0;
         if (restart_i || rx_empty_i) begin
            count <= '0;
            armed <= 1'b1;
         end else if (bit_tick_i && armed) begin
            if (count + 1'b1 >= limit) begin
               expire_o <= 1'b1; // R12
               armed <= 1'b0;
            end
            count <= count + 1'b1;
         end
      end
   end
endmodule : uifc_rx_timer
`default_nettype wire

// *** uifc_prio_enc.sv ***
// Priority encoder from pending interrupt sources to the six-bit status code.
`timescale 1ns/10ps
`default_nettype none
module uifc_prio_enc (
   input wire logic [6:0] pend_i,
   output logic [5:0] code_o,
   output logic any_o
);
   // Index 0 is the highest priority: line, time-out, receive, transmit,
   // modem, Xoff or special, RTS or CTS.
   always_comb begin
      any_o = |pend_i; // R18
      if (pend_i[0]) begin
         code_o = uifc_pkg::CODE_LS; // R17
      end else if (pend_i[1]) begin
         code_o = uifc_pkg::CODE_TO; // R17
      end else if (pend_i[2]) begin
         code_o = uifc_pkg::CODE_RX; // R17
      end else if (pend_i[3]) begin
         code_o = uifc_pkg::CODE_TX; // R17
      end else if (pend_i[4]) begin
         code_o = uifc_pkg::CODE_MS; // R17
      end else if (pend_i[5]) begin
         code_o = uifc_pkg::CODE_XS; // R17
      end else if (pend_i[6]) begin
         code_o = uifc_pkg::CODE_RC; // R17
      end else begin
         code_o = uifc_pkg::CODE_NONE; // R14
      end
   end
endmodule : uifc_prio_enc
`default_nettype wire

// *** uifc_top.sv ***
// Interrupt enable, prioritised status and FIFO control of one channel, APB slave.
`timescale 1ns/10ps
`default_nettype none
module uifc_top (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [uifc_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [uifc_pkg::DATA_W-1:0] pwdata_i,
   output logic [uifc_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   input wire logic rx_push_i,
   input wire logic rx_empty_i,
   input wire logic rx_trig_i,
   input wire logic [7:0] rx_data_i,
   input wire logic overrun_i,
   input wire logic [2:0] rx_err_i,
   input wire logic [2:0] head_err_i,
   input wire logic fifo_err_any_i,
   input wire logic thr_empty_i,
   input wire logic tx_trig_i,
   input wire logic tx_fifo_empty_i,
   input wire logic tx_all_empty_i,
   input wire logic half_duplex_i,
   input wire logic [7:0] modem_status_i,
   input wire logic xoff_det_i,
   input wire logic xon_det_i,
   input wire logic special_det_i,
   input wire logic rts_rise_i,
   input wire logic cts_rise_i,
   input wire logic auto_rts_i,
   input wire logic auto_cts_i,
   input wire logic wake_i,
   input wire logic bit_tick_i,
   input wire logic [3:0] char_bits_i,
   output logic fifo_en_o,
   output logic dma_mode_o,
   output logic [1:0] rx_trig_sel_o,
   output logic [1:0] tx_trig_sel_o,
   output logic rx_fifo_rst_o,
   output logic tx_fifo_rst_o,
   output logic rx_pop_o,
   output logic tx_push_o,
   output logic [7:0] tx_data_o,
   output logic ms_rd_o,
   output logic sleep_en_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic [7:0] int_enable;
   logic [7:0] ext_feature;
   logic [7:0] ext_mode;
   logic ext_on;
   logic access;
   logic done;
   logic wr_done;
   logic rd_done;
   logic hit;
   logic [7:0] status_byte;
   logic [7:0] line_byte;
   logic [5:0] code;
   logic any_pend;
   logic [6:0] pend;
   logic data_ready;
   logic overrun;
   logic ls_pend;
   logic to_pend;
   logic tx_pend;
   logic xs_pend;
   logic xs_special;
   logic rc_pend;
   logic wake_pend;
   logic tx_cond;
   logic tx_cond_q;
   logic to_expire;
   logic [31:0] next_rdata;

   assign ext_on = ext_feature[uifc_pkg::EFR_EXT];
   assign access = psel_i && penable_i;
   // One wait state: the answer comes on the second access cycle.
   assign done = access && pready_o;
   assign wr_done = done && pwrite_i;
   assign rd_done = done && !pwrite_i;

   function automatic logic is_at(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : is_at

   always_comb begin
      hit = 1'b1;
      next_rdata = '0;
      if (is_at(paddr_i, uifc_pkg::OFF_INT_ENABLE)) begin
         next_rdata = {24'h000000, int_enable};
      end else if (is_at(paddr_i, uifc_pkg::OFF_INT_STATUS)) begin
         next_rdata = {24'h000000, status_byte};
      end else if (is_at(paddr_i, uifc_pkg::OFF_FIFO_CONTROL)) begin
         next_rdata = '0;
      end else if (is_at(paddr_i, uifc_pkg::OFF_LINE_STATUS)) begin
         next_rdata = {24'h000000, line_byte};
      end else if (is_at(paddr_i, uifc_pkg::OFF_MODEM_STATUS)) begin
         next_rdata = {24'h000000, modem_status_i};
      end else if (is_at(paddr_i, uifc_pkg::OFF_RX_HOLDING)) begin
         next_rdata = {24'h000000, rx_data_i};
      end else if (is_at(paddr_i, uifc_pkg::OFF_TX_HOLDING)) begin
         next_rdata = '0;
      end else if (is_at(paddr_i, uifc_pkg::OFF_EXT_FEATURE)) begin
         next_rdata = {24'h000000, ext_feature};
      end else if (is_at(paddr_i, uifc_pkg::OFF_EXT_MODE)) begin
         next_rdata = {24'h000000, ext_mode};
      end else begin
         hit = 1'b0;
      end
   end

   // Read data is captured one edge before the completing edge, so any
   // clear caused by the read lands after the host has its value.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= '0;
      end else begin
         pready_o <= access && !pready_o;
         if (access && !pready_o) begin
            prdata_o <= pwrite_i ? '0 : next_rdata; // R25
            pslverr_o <= !hit;
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

   logic wr_ier;
   logic wr_fcr;
   logic rd_isr;
   logic rd_lsr;
   logic rd_msr;
   logic rd_rhr;
   logic wr_thr;
   assign wr_ier = wr_done && is_at(paddr_i, uifc_pkg::OFF_INT_ENABLE);
   assign wr_fcr = wr_done && is_at(paddr_i, uifc_pkg::OFF_FIFO_CONTROL);
   assign wr_thr = wr_done && is_at(paddr_i, uifc_pkg::OFF_TX_HOLDING);
   assign rd_isr = rd_done && is_at(paddr_i, uifc_pkg::OFF_INT_STATUS);
   assign rd_lsr = rd_done && is_at(paddr_i, uifc_pkg::OFF_LINE_STATUS);
   assign rd_msr = rd_done && is_at(paddr_i, uifc_pkg::OFF_MODEM_STATUS);
   assign rd_rhr = rd_done && is_at(paddr_i, uifc_pkg::OFF_RX_HOLDING);

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         int_enable <= uifc_pkg::IER_RST;
         ext_feature <= uifc_pkg::EFR_RST;
         ext_mode <= uifc_pkg::EXTENDED_MODE_STATUS_RST;
      end else begin
         if (wr_ier) begin
            int_enable[3:0] <= pwdata_i[3:0];
            if (ext_on) begin
               int_enable[7:4] <= pwdata_i[7:4]; // R08
            end
         end
         if (wr_done && is_at(paddr_i, uifc_pkg::OFF_EXT_FEATURE)) begin
            ext_feature <= pwdata_i[7:0];
         end
         if (wr_done && is_at(paddr_i, uifc_pkg::OFF_EXT_MODE)) begin
            ext_mode <= pwdata_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         fifo_en_o <= 1'b0;
         dma_mode_o <= 1'b0;
         rx_trig_sel_o <= 2'h0;
         tx_trig_sel_o <= 2'h0;
         rx_fifo_rst_o <= 1'b0;
         tx_fifo_rst_o <= 1'b0;
      end else begin
         rx_fifo_rst_o <= 1'b0;
         tx_fifo_rst_o <= 1'b0;
         if (wr_fcr) begin
            fifo_en_o <= pwdata_i[uifc_pkg::FCR_EN]; // R21
            // Without the enable bit the rest of the byte is dropped.
            if (pwdata_i[uifc_pkg::FCR_EN]) begin
               rx_fifo_rst_o <= pwdata_i[uifc_pkg::FCR_RX_RST]; // R22
               tx_fifo_rst_o <= pwdata_i[uifc_pkg::FCR_TX_RST]; // R23
               dma_mode_o <= pwdata_i[uifc_pkg::FCR_DMA];
               rx_trig_sel_o <= pwdata_i[uifc_pkg::FCR_RX_TRIG +: 2];
               if (ext_on) begin
                  tx_trig_sel_o <= pwdata_i[uifc_pkg::FCR_TX_TRIG +: 2];
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_pop_o <= 1'b0;
         tx_push_o <= 1'b0;
         tx_data_o <= 8'h00;
         ms_rd_o <= 1'b0;
         sleep_en_o <= 1'b0;
      end else begin
         rx_pop_o <= rd_rhr;
         tx_push_o <= wr_thr;
         ms_rd_o <= rd_msr; // R15
         sleep_en_o <= int_enable[uifc_pkg::IER_SLEEP] && ext_on;
         if (wr_thr) begin
            tx_data_o <= pwdata_i[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line status.

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         data_ready <= 1'b0;
      end else if (rx_push_i) begin
         data_ready <= 1'b1; // R02
      end else if (rx_empty_i) begin
         data_ready <= 1'b0; // R02
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         overrun <= 1'b0;
      end else if (overrun_i) begin
         overrun <= 1'b1;
      end else if (rd_lsr) begin
         overrun <= 1'b0;
      end
   end

   assign line_byte = {fifo_err_any_i, tx_all_empty_i, thr_empty_i, head_err_i,
                       overrun, data_ready}; // R03

   // Byte errors interrupt when the bad byte is read out, or at once on request; overrun always interrupts at once.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ls_pend <= 1'b0;
      end else if (overrun_i || (rx_push_i && ext_mode[uifc_pkg::EXTENDED_MODE_STATUS_IMM_ERR] && |rx_err_i)
                   || (rd_rhr && !ext_mode[uifc_pkg::EXTENDED_MODE_STATUS_IMM_ERR] && |head_err_i)) begin
         ls_pend <= 1'b1; // R06
      end else if (rd_lsr) begin
         ls_pend <= 1'b0; // R15
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky sources.

   uifc_rx_timer u_timer (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .bit_tick_i(bit_tick_i),
      .char_bits_i(char_bits_i),
      .rx_empty_i(rx_empty_i),
      .restart_i(rx_push_i || rd_rhr),
      .expire_o(to_expire)
   );

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         to_pend <= 1'b0;
      end else if (to_expire) begin
         to_pend <= 1'b1; // R12
      end else if (rd_rhr) begin
         to_pend <= 1'b0; // R15
      end
   end

   always_comb begin
      if (!fifo_en_o) begin
         tx_cond = thr_empty_i;
      end else if (half_duplex_i) begin
         tx_cond = tx_all_empty_i; // R13
      end else begin
         tx_cond = tx_trig_i || tx_fifo_empty_i; // R13
      end
   end

   // Edge of the ready condition, or the enable turned on while already ready.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         tx_cond_q <= 1'b0;
         tx_pend <= 1'b0;
      end else begin
         tx_cond_q <= tx_cond;
         if ((tx_cond && !tx_cond_q)
             || (wr_ier && pwdata_i[uifc_pkg::IER_TX] && !int_enable[uifc_pkg::IER_TX]
                 && tx_cond)) begin
            tx_pend <= 1'b1; // R05
         end else if (wr_thr || (rd_isr && code == uifc_pkg::CODE_TX)) begin
            tx_pend <= 1'b0; // R15
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         xs_pend <= 1'b0;
         xs_special <= 1'b0;
      end else if (xoff_det_i || special_det_i) begin
         xs_pend <= 1'b1;
         xs_special <= special_det_i;
      end else if ((rd_isr && code == uifc_pkg::CODE_XS) || (xon_det_i && !xs_special)
                   || (rx_push_i && xs_special)) begin
         xs_pend <= 1'b0; // R16
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rc_pend <= 1'b0;
      end else if ((rts_rise_i && auto_rts_i && int_enable[uifc_pkg::IER_RTS])
                   || (cts_rise_i && auto_cts_i && int_enable[uifc_pkg::IER_CTS])) begin
         rc_pend <= 1'b1; // R09 R10
      end else if (rd_msr) begin
         rc_pend <= 1'b0; // R16
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wake_pend <= 1'b0;
      end else if (wake_i) begin
         wake_pend <= 1'b1; // R14
      end else if (rd_isr) begin
         wake_pend <= 1'b0; // R14
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority and interrupt output.

   assign pend[0] = ls_pend && int_enable[uifc_pkg::IER_LS]; // R06
   assign pend[1] = to_pend && int_enable[uifc_pkg::IER_RX];
   assign pend[2] = int_enable[uifc_pkg::IER_RX]
                    && (fifo_en_o ? rx_trig_i : !rx_empty_i); // R01 R04
   assign pend[3] = tx_pend && int_enable[uifc_pkg::IER_TX]; // R05
   assign pend[4] = |modem_status_i[3:0] && int_enable[uifc_pkg::IER_MS]; // R07
   assign pend[5] = xs_pend && ext_on && int_enable[uifc_pkg::IER_XOFF]; // R19
   assign pend[6] = rc_pend && ext_on; // R19

   uifc_prio_enc u_prio (
      .pend_i(pend),
      .code_o(code),
      .any_o(any_pend)
   );

   // Leaving sleep forces bit 0 high until the host reads the status once.
   assign status_byte = {fifo_en_o, fifo_en_o, code[5:1], code[0] || wake_pend}; // R11 R14 R20

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= any_pend; // R24
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_access;
      psel_i && penable_i;
   endsequence

   a_bus_wait_state: assert property (s_setup ##1 s_access |-> !pready_o ##1 pready_o)
      else $error("answer not on second access cycle");
   a_irq_tracks_pend: assert property (any_pend |=> irq_o) // R24
      else $error("pending source without interrupt");
   a_irq_idle_low: assert property (!any_pend |=> !irq_o) // R18
      else $error("interrupt without pending source");
   a_fcr_ignored: assert property (wr_fcr && !pwdata_i[0] |=> !fifo_en_o && !rx_fifo_rst_o) // R21
      else $error("FIFO control bits taken without enable");
   a_rx_reset_pulse: assert property (wr_fcr && pwdata_i[0] && pwdata_i[1]
                                      |=> rx_fifo_rst_o ##1 !rx_fifo_rst_o) // R22
      else $error("receive FIFO reset not a single pulse");
   a_tx_reset_pulse: assert property (wr_fcr && pwdata_i[0] && pwdata_i[2]
                                      |=> tx_fifo_rst_o ##1 !tx_fifo_rst_o) // R23
      else $error("transmit FIFO reset not a single pulse");
   a_ier_hi_locked: assert property (wr_ier && !ext_on
                                     |=> int_enable[7:4] == $past(int_enable[7:4])) // R08
      else $error("upper enables written without extended enable");
   a_ready_on_push: assert property (rx_push_i |=> data_ready) // R02
      else $error("data ready not set on push");
   a_ready_clears: assert property (rx_empty_i && !rx_push_i |=> !data_ready) // R02
      else $error("data ready not cleared on empty");
   a_tx_write_clear: assert property (wr_thr && !(tx_cond && !tx_cond_q) |=> !tx_pend) // R15
      else $error("holding write did not clear transmit ready");
   a_status_fifo_bits: assert property (access && !pready_o && !pwrite_i
                                        && paddr_i == uifc_pkg::OFF_INT_STATUS
                                        |=> prdata_o[7:6] == {2{fifo_en_o}}
                                            && prdata_o[5:0]
                                               == $past({code[5:1], code[0] || wake_pend})) // R11 R20
      else $error("status read value wrong");
endmodule : uifc_top
`default_nettype wire

// *** uifc_host.sv ***
// Host processor model that drives the APB side of the channel block.
`timescale 1ns/10ps
`default_nettype none
module uifc_host (
   input wire logic clk_i,
   input wire logic [31:0] prdata_i,
   input wire logic pready_i,
   input wire logic pslverr_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [7:0] paddr_o,
   output logic [31:0] pwdata_o,
   output logic hung_o
);
   initial begin
      psel_o = 1'h0;
      penable_o = 1'h0;
      pwrite_o = 1'h0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
      hung_o = 1'h0;
   end
   ////////////////////////////////////////
   // The request is held until pready is seen at an edge, for at most 50 cycles, after which hung is raised.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk_i);
      psel_o <= 1'h1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'h1 && n < 50);
      if (pready_i !== 1'h1) hung_o <= 1'h1;
      rd = prdata_i;
      er = pslverr_i;
      psel_o <= 1'h0;
      penable_o <= 1'h0;
   endtask : xfer
endmodule : uifc_host
`default_nettype wire

// *** uifc_tb_top.sv ***
// Self-checking bench for the channel interrupt, status and FIFO control block.
`timescale 1ns/10ps
`default_nettype none
module uifc_tb_top;
   localparam logic [7:0] IE = uifc_pkg::OFF_INT_ENABLE;
   localparam logic [7:0] IS = uifc_pkg::OFF_INT_STATUS;
   localparam logic [7:0] FC = uifc_pkg::OFF_FIFO_CONTROL;
   localparam logic [7:0] LS = uifc_pkg::OFF_LINE_STATUS;
   localparam logic [7:0] MS = uifc_pkg::OFF_MODEM_STATUS;
   localparam logic [7:0] RH = uifc_pkg::OFF_RX_HOLDING;
   localparam logic [7:0] TH = uifc_pkg::OFF_TX_HOLDING;
   localparam logic [7:0] EF = uifc_pkg::OFF_EXT_FEATURE;
   localparam int OV = 0, XF = 1, XN = 2, RT = 3, CT = 4, PU = 5, WK = 6, SP = 7;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} uifc_row_t;
   logic clk_i = 1'h0, resetn_i = 1'h0, tick_on = 1'h0, hung, er;
   logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
   logic [7:0] paddr_i, tx_data_o;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [7:0] ev = 8'h00;
   wire logic special_det_i = ev[SP];
   wire logic overrun_i = ev[OV], xoff_det_i = ev[XF], xon_det_i = ev[XN];
   wire logic rts_rise_i = ev[RT], cts_rise_i = ev[CT], rx_push_i = ev[PU], wake_i = ev[WK];
   logic rx_empty_i = 1'h1, rx_trig_i = 1'h0, fifo_err_any_i = 1'h0;
   logic [7:0] rx_data_i = 8'h5A, modem_status_i = 8'h00;
   logic [2:0] rx_err_i = 3'h0, head_err_i = 3'h0;
   logic thr_empty_i = 1'h0, tx_trig_i = 1'h0, tx_fifo_empty_i = 1'h0, tx_all_empty_i = 1'h0;
   logic half_duplex_i = 1'h0, auto_rts_i = 1'h0, auto_cts_i = 1'h0, bit_tick_i = 1'h0;
   logic [3:0] char_bits_i = 4'h8;
   logic fifo_en_o, dma_mode_o, rx_fifo_rst_o, tx_fifo_rst_o, rx_pop_o, tx_push_o;
   logic ms_rd_o, sleep_en_o;
   logic [1:0] rx_trig_sel_o, tx_trig_sel_o;
   int n_fail = 0, cmp_count = 0, n_rxr = 0, n_txr = 0, n_pls = 0;
   uifc_row_t rows [10] = '{
      '{1'h1, IE, 32'hFF, 32'h0}, '{1'h0, IE, 32'h0, 32'h0F},
      '{1'h1, FC, 32'h01, 32'h0}, '{1'h0, IS, 32'h0, 32'hC1},
      '{1'h1, EF, 32'h10, 32'h0}, '{1'h1, IE, 32'hFF, 32'h0},
      '{1'h0, IE, 32'h0, 32'hFF}, '{1'h0, FC, 32'h0, 32'h0},
      '{1'h1, IE, 32'h00, 32'h0}, '{1'h0, 8'h24, 32'h0, 32'h0}};

   uifc_top uifc_top_i (.*);
   uifc_host uifc_host_i (.clk_i(clk_i), .prdata_i(prdata_o), .pready_i(pready_o),
      .pslverr_i(pslverr_o), .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
      .paddr_o(paddr_i), .pwdata_o(pwdata_i), .hung_o(hung));

   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) bit_tick_i <= tick_on & ~bit_tick_i;
   always @(posedge clk_i) begin
      if (rx_fifo_rst_o === 1'h1) n_rxr++;
      if (tx_fifo_rst_o === 1'h1) n_txr++;
      n_pls += int'(rx_pop_o === 1'h1) + int'(tx_push_o === 1'h1) + int'(ms_rd_o === 1'h1);
   end
   always @(posedge hung) begin
      n_fail++;
      end_sim();
   end
   ////////////////////////////////////////
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      uifc_host_i.xfer(w, a, d, rd, er);
   endtask : xf
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      xf(1'h0, a, 32'h0);
      chk(rd, e);
   endtask : rchk
   // Two spare cycles let the event flag and the registered interrupt settle.
   task automatic pulse(input int b);
      @(posedge clk_i) ev[b] <= 1'h1;
      @(posedge clk_i) ev[b] <= 1'h0;
      repeat (2) @(posedge clk_i);
   endtask : pulse
   ////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'h1;
      rchk(IS, 32'h01);
      chk(32'(irq_o), 32'h0);
      foreach (rows[i]) begin
         xf(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(rd, rows[i].e);
         chk(32'(er), 32'(rows[i].a > 8'h20));
      end
      xf(1'h1, FC, 32'hFF);
      repeat (3) @(posedge clk_i);
      chk(n_rxr, 1);
      chk(n_txr, 1);
      chk(32'({dma_mode_o, rx_trig_sel_o, tx_trig_sel_o, fifo_en_o}), 32'h3F);
      xf(1'h1, FC, 32'h06);
      repeat (3) @(posedge clk_i);
      chk(n_rxr + n_txr, 2);
      chk(32'({dma_mode_o, rx_trig_sel_o, tx_trig_sel_o, fifo_en_o}), 32'h3E);
      rchk(IS, 32'h01);
      xf(1'h1, FC, 32'h01);
      xf(1'h1, IE, 32'h0F);
      modem_status_i <= 8'h01;
      rx_trig_i <= 1'h1;
      rx_empty_i <= 1'h0;
      pulse(PU);
      pulse(OV);
      chk(32'(irq_o), 32'h1);
      rchk(IS, 32'hC6);
      head_err_i <= 3'h5;
      fifo_err_any_i <= 1'h1;
      thr_empty_i <= 1'h1;
      rchk(LS, 32'hB7);
      rchk(IS, 32'hC4);
      rx_trig_i <= 1'h0;
      rchk(IS, 32'hC0);
      modem_status_i <= 8'h00;
      rchk(IS, 32'hC1);
      chk(32'(irq_o), 32'h0);
      tx_trig_i <= 1'h1;
      rchk(IS, 32'hC2);
      rchk(IS, 32'hC1);
      xf(1'h1, IE, 32'h0D);
      xf(1'h1, IE, 32'h0F);
      rchk(IS, 32'hC2);
      xf(1'h1, IE, 32'h0D);
      xf(1'h1, IE, 32'h0F);
      xf(1'h1, TH, 32'hA5);
      rchk(IS, 32'hC1);
      chk(32'(tx_data_o), 32'hA5);
      tx_trig_i <= 1'h0;
      xf(1'h1, IE, 32'hF0);
      pulse(XF);
      chk(32'(sleep_en_o), 32'h1);
      rchk(IS, 32'hD0);
      pulse(XF);
      chk(32'(irq_o), 32'h1);
      pulse(XN);
      rchk(IS, 32'hC1);
      pulse(SP);
      chk(32'(irq_o), 32'h1);
      pulse(PU);
      rchk(IS, 32'hC1);
      auto_rts_i <= 1'h1;
      pulse(RT);
      rchk(IS, 32'hE0);
      rchk(MS, 32'h00);
      rchk(IS, 32'hC1);
      auto_cts_i <= 1'h1;
      pulse(CT);
      rchk(IS, 32'hE0);
      rchk(MS, 32'h00);
      xf(1'h1, IE, 32'h01);
      pulse(PU);
      tick_on <= 1'h1;
      repeat (76) @(posedge clk_i);
      rchk(IS, 32'hC1);
      repeat (20) @(posedge clk_i);
      rchk(IS, 32'hCC);
      pulse(WK);
      rchk(IS, 32'hCD);
      rchk(IS, 32'hCC);
      tick_on <= 1'h0;
      rchk(RH, 32'h5A);
      rchk(IS, 32'hC1);
      chk(n_pls, 4);
      end_sim();
   end
endmodule : uifc_tb_top
`default_nettype wire
